// ### rtl/hbfs_pkg.sv
package hbfs_pkg;

	// ----------------------------------------------------------------
	// Word layout
	// ----------------------------------------------------------------
	localparam int WORD_W      = 16;   // Serial word width
	localparam int NUM_SW      = 6;    // Three low-side, three high-side
	localparam int BIT_SRR     = 0;    // Input: status-reset command
	localparam int BIT_SW_LO   = 1;    // Input/output: first switch bit
	localparam int BIT_OCS     = 13;   // Input: overcurrent-shutdown enable
	localparam int BIT_TP      = 0;    // Output: prewarning flag
	localparam int BIT_SCD     = 13;   // Output: short-detect flag
	localparam int BIT_OPL     = 14;   // Output: open-load flag
	localparam int BIT_PSF     = 15;   // Output: supply-fail flag

	// Input register value after power-on reset
	localparam logic [15:0] IN_RESET = 16'h2000;

	// ----------------------------------------------------------------
	// Timing (ns at a 10 ns clock)
	// ----------------------------------------------------------------
	localparam int CLK_NS      = 10;
	localparam int UV_DELAY_NS = 10000;  // Undervoltage filter, least time
	localparam int SD_DELAY_NS = 10000;  // Shutdown / open-load filter
	localparam int POR_NS      = 30000;  // Internal power-on reset
	localparam int UV_CYC  = (UV_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int SD_CYC  = (SD_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int POR_CYC = (POR_NS + CLK_NS - 1) / CLK_NS;

	// Analog comparator results
	typedef struct packed {
		logic       uv;        // Supply below undervoltage threshold
		logic       tp_set;    // Any stage above prewarn set threshold
		logic       tp_reset;  // Any stage below prewarn reset threshold
		logic       tsd_off;   // Any stage above shutdown threshold
		logic       tsd_on;    // All stages below switch-on threshold
		logic [5:0] open_ld;   // Per stage: current below open-load level
		logic [5:0] over_i;    // Per stage: current above shutdown level
	} hbfs_sense_t;

	typedef enum logic [1:0] {
		HBFS_SLEEP,
		HBFS_POR,
		HBFS_RUN
	} hbfs_state_t;

endpackage : hbfs_pkg

// ### rtl/hbfs_filter.sv
`timescale 1ns/1ps
`default_nettype none

// Counts how long a condition holds; fires once past the delay
module hbfs_filter #(
	parameter int CYC = 1000
) (
	input  wire logic i_clk,
	input  wire logic i_rstn,
	input  wire logic i_cond,
	output var  logic o_hit
);

	localparam int CW = $clog2(CYC + 1);

	logic [CW-1:0] cnt;   // Cycles the condition has held

	// Restarts whenever the condition drops, so glitches never add up
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt <= '0;
		end else if (!i_cond) begin
			cnt <= '0;
		end else if (cnt != CW'(CYC)) begin
			cnt <= cnt + 1'b1;
		end
	end

	assign o_hit = i_cond && (cnt == CW'(CYC));

endmodule // hbfs_filter

`default_nettype wire

// ### rtl/hbfs_core.sv
`timescale 1ns/1ps
`default_nettype none


module hbfs_core #(
	parameter int UV_CYC  = hbfs_pkg::UV_CYC,
	parameter int SD_CYC  = hbfs_pkg::SD_CYC,
	parameter int POR_CYC = hbfs_pkg::POR_CYC
) (
	input  wire logic                 i_clk,
	input  wire logic                 i_rstn,
	input  wire logic                 i_sleep_control_pin,
	input  wire logic                 i_cs_n,
	input  wire logic                 i_sclk,
	input  wire logic                 i_serial_in_pin,
	input  wire hbfs_pkg::hbfs_sense_t i_sense,
	output var  logic                 o_serial_out,
	output var  logic                 o_serial_out_en,
	output var  logic [5:0]           o_switch_on,
	output var  logic                 o_switch_hiz,
	output var  logic                 o_current_limit,
	output var  logic [15:0]          o_in_word,
	output var  logic [15:0]          o_out_word
);

	// ----------------------------------------------------------------
	// State and storage
	// ----------------------------------------------------------------
	hbfs_pkg::hbfs_state_t state;            // Sleep / power-on / run
	hbfs_pkg::hbfs_state_t next_state;
	logic [15:0]           in_reg;           // Latched input word
	logic [15:0]           shift;            // Serial shift register
	logic [4:0]            nbits;            // Bits shifted this frame
	logic                  sclk_d;           // Serial clock, last cycle
	logic                  cs_d;             // Select, last cycle
	logic [31:0]           por_cnt;          // Internal reset counter
	logic                  supply_fail_flag; // Sticky supply-fail
	logic                  open_load_flag;   // Sticky open-load
	logic                  temp_prewarn_flag;// Self-clearing prewarning
	logic                  short_detect_flag;// Sticky short-detect
	logic                  tsd_latch;        // Thermal shutdown active
	logic [5:0]            oc_off;           // Stages off by overcurrent

	// ----------------------------------------------------------------
	// Decoding
	// ----------------------------------------------------------------
	wire        awake     = (state != hbfs_pkg::HBFS_SLEEP);
	wire        running   = (state == hbfs_pkg::HBFS_RUN);
	wire        sclk_rise = i_sclk && !sclk_d;
	wire        cs_fall   = !i_cs_n && cs_d;
	wire        cs_rise   = i_cs_n && !cs_d;
	// Only a whole word counts; an early select rise is an abort
	wire        word_done = cs_rise && (nbits == 5'd16);
	wire [15:0] new_word  = shift;
	wire        status_reset_cmd = word_done && running &&
		new_word[hbfs_pkg::BIT_SRR];
	wire        ocs_en    = in_reg[hbfs_pkg::BIT_OCS];
	wire [5:0]  sw_req    = in_reg[hbfs_pkg::BIT_SW_LO +: 6];
	wire        uv_hit;
	wire        ol_hit;
	wire        oc_hit;
	wire [5:0]  oc_stage  = i_sense.over_i;
	// Outputs drop at once on undervoltage, come back with supply
	wire        uv_block  = i_sense.uv;
	wire [5:0]  sw_live   = sw_req & ~oc_off &
		{6{running && !tsd_latch && !uv_block}};
	wire [15:0] out_word;

	// ----------------------------------------------------------------
	// Delay filters
	// ----------------------------------------------------------------
	hbfs_filter #(.CYC(UV_CYC)) u_uv (
		.i_clk  (i_clk),
		.i_rstn (i_rstn),
		.i_cond (running && i_sense.uv),
		.o_hit  (uv_hit)
	);

	// Open load only counts on stages that are switched on
	hbfs_filter #(.CYC(SD_CYC)) u_ol (
		.i_clk  (i_clk),
		.i_rstn (i_rstn),
		.i_cond (|(i_sense.open_ld & sw_live)),
		.o_hit  (ol_hit)
	);

	hbfs_filter #(.CYC(SD_CYC)) u_oc (
		.i_clk  (i_clk),
		.i_rstn (i_rstn),
		.i_cond (|(oc_stage & sw_live)),
		.o_hit  (oc_hit)
	);

	// ----------------------------------------------------------------
	// Power state
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			hbfs_pkg::HBFS_SLEEP: begin
				if (i_sleep_control_pin) begin
					next_state = hbfs_pkg::HBFS_POR;
				end
			end
			hbfs_pkg::HBFS_POR: begin
				if (!i_sleep_control_pin) begin
					next_state = hbfs_pkg::HBFS_SLEEP;
				end else if (por_cnt == 32'(POR_CYC - 1)) begin
					next_state = hbfs_pkg::HBFS_RUN;
				end
			end
			hbfs_pkg::HBFS_RUN: begin
				if (!i_sleep_control_pin) begin
					next_state = hbfs_pkg::HBFS_SLEEP;
				end
			end
		endcase
	end

	// State register
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state <= hbfs_pkg::HBFS_SLEEP;
		end else begin
			state <= next_state;
		end
	end

	// Power-on reset length counter
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			por_cnt <= '0;
		end else if (state != hbfs_pkg::HBFS_POR) begin
			por_cnt <= '0;
		end else begin
			por_cnt <= por_cnt + 32'd1;
		end
	end

	// ----------------------------------------------------------------
	// Serial port
	// ----------------------------------------------------------------
	// Edge history; pins are taken as synchronous
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			sclk_d <= 1'b0;
			cs_d   <= 1'b1;
		end else begin
			sclk_d <= i_sclk;
			cs_d   <= i_cs_n;
		end
	end

	// Load status at select fall, shift in on clock rise
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			shift <= '0;
			nbits <= '0;
		end else if (cs_fall) begin
			shift <= out_word;
			nbits <= '0;
		end else if (!i_cs_n && sclk_rise) begin
			// LSB first, so bit 0 (prewarning) leads the frame
			shift <= {i_serial_in_pin, shift[15:1]};
			if (nbits != 5'd16) begin
				nbits <= nbits + 5'd1;
			end
		end
	end

	// LSB out; bit 0 shows prewarning from select fall
	assign o_serial_out    = shift[0];
	assign o_serial_out_en = !i_cs_n && awake;

	// Input register: power-on value, loaded only on whole words
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			in_reg <= hbfs_pkg::IN_RESET;
		end else if (!running) begin
			in_reg <= hbfs_pkg::IN_RESET;
		end else if (word_done) begin
			// Status-reset bit is one-shot, never stored
			in_reg <= new_word & ~16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Fault flags; a new detection beats a status-reset
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			supply_fail_flag  <= 1'b0;
			open_load_flag    <= 1'b0;
			short_detect_flag <= 1'b0;
		end else if (!running) begin
			supply_fail_flag  <= 1'b0;
			open_load_flag    <= 1'b0;
			short_detect_flag <= 1'b0;
		end else begin
			supply_fail_flag  <= uv_hit ||
				(supply_fail_flag && !status_reset_cmd);
			open_load_flag    <= ol_hit ||
				(open_load_flag && !status_reset_cmd);
			short_detect_flag <= oc_hit ||
				(short_detect_flag && !status_reset_cmd);
		end
	end

	// Prewarning with hysteresis: set above, clear below
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			temp_prewarn_flag <= 1'b0;
		end else if (!running) begin
			temp_prewarn_flag <= 1'b0;
		end else if (i_sense.tp_set) begin
			temp_prewarn_flag <= 1'b1;
		end else if (i_sense.tp_reset) begin
			temp_prewarn_flag <= 1'b0;
		end
	end

	// Thermal shutdown: released when cool and reset commanded, or on leaving run
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tsd_latch <= 1'b0;
		end else if (!running) begin
			tsd_latch <= 1'b0;
		end else if (i_sense.tsd_off) begin
			tsd_latch <= 1'b1;
		end else if (status_reset_cmd && i_sense.tsd_on) begin
			tsd_latch <= 1'b0;
		end
	end

	// Overcurrent shutdown per stage, only with the enable set
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			oc_off <= '0;
		end else if (!running) begin
			oc_off <= '0;
		end else if (oc_hit && ocs_en) begin
			oc_off <= oc_off | (oc_stage & sw_live);
		end else if (status_reset_cmd) begin
			oc_off <= '0;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Status bits show real switch states; reset does not touch them
	assign out_word = {supply_fail_flag, open_load_flag,
		short_detect_flag, 6'h00, sw_live,
		temp_prewarn_flag};

	// Registered copies of data outputs
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_switch_on <= '0;
			o_in_word   <= hbfs_pkg::IN_RESET;
			o_out_word  <= '0;
		end else begin
			o_switch_on <= sw_live;
			o_in_word   <= in_reg;
			o_out_word  <= out_word;
		end
	end

	// Sleep puts every switch in high impedance
	assign o_switch_hiz    = !running || (o_switch_on == 6'h00);
	// Regulator stays on regardless of the shutdown enable
	assign o_current_limit = 1'b1;

endmodule // hbfs_core

`default_nettype wire

// ### verification/hbfs_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Watches fault flags and switch states at the core's ports
module hbfs_core_asserts #(
	parameter int UV_CYC  = 4,
	parameter int SD_CYC  = 4,
	parameter int POR_CYC = 8
) (
	input wire logic                  i_clk,
	input wire logic                  i_rstn,
	input wire logic                  i_sleep_control_pin,
	input wire logic                  i_cs_n,
	input wire hbfs_pkg::hbfs_sense_t i_sense,
	input wire logic [5:0]            o_switch_on,
	input wire logic                  o_current_limit,
	input wire logic [15:0]           o_in_word,
	input wire logic [15:0]           o_out_word
);
	logic [3:0] cs_age;       // Cycles since select was last low
	logic [3:0] sl_age;       // Cycles since sleep was last low
	logic [3:0] next_cs_age;
	logic [3:0] next_sl_age;
	// Saturate so long idle runs never wrap back to "recent"
	assign next_cs_age = !i_cs_n ? 4'h0 : cs_age + {3'h0, cs_age != 4'hF};
	assign next_sl_age = !i_sleep_control_pin ? 4'h0
		: sl_age + {3'h0, sl_age != 4'hF};
	// Age counters
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cs_age <= 4'h0;
			sl_age <= 4'h0;
		end else begin
			cs_age <= next_cs_age;
			sl_age <= next_sl_age;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	// Sticky flags may only drop just after a transfer or a sleep
	sequence s_recent_cmd;
		cs_age < 4'h8 || sl_age < 4'h8;
	endsequence
	chk_limit_always: assert property (o_current_limit)
		else $error("current limit not active");
	chk_sleep_erase: assert property (!i_sleep_control_pin[*4] |->
		o_switch_on == 6'h00 && o_out_word == 16'h0000)
		else $error("sleep did not erase outputs");
	chk_sleep_inreg: assert property (!i_sleep_control_pin[*4] |->
		o_in_word == 16'h2000)
		else $error("input word not at reset value");
	chk_uv_off: assert property (i_sense.uv[*4] |->
		o_switch_on == 6'h00)
		else $error("outputs on during undervoltage");
	chk_psf_sticky: assert property ($fell(o_out_word[15]) |->
		s_recent_cmd)
		else $error("supply flag dropped by itself");
	chk_opl_sticky: assert property ($fell(o_out_word[14]) |->
		s_recent_cmd)
		else $error("open-load flag dropped by itself");
	chk_scd_sticky: assert property ($fell(o_out_word[13]) |->
		s_recent_cmd)
		else $error("short flag dropped by itself");
	chk_tp_set: assert property ((i_sense.tp_set && o_switch_on != 6'h00)[*4]
		|-> o_out_word[0])
		else $error("prewarning not raised");
	chk_tp_clear: assert property ((i_sense.tp_reset && !i_sense.tp_set)[*4]
		|-> !o_out_word[0])
		else $error("prewarning not cleared");
	chk_tsd_off: assert property (i_sense.tsd_off[*4] |->
		o_switch_on == 6'h00 && o_out_word[6:1] == 6'h00)
		else $error("outputs on in thermal shutdown");
	chk_status_mirror: assert property ($stable(o_switch_on)[*3] |->
		o_out_word[6:1] == o_switch_on)
		else $error("status bits differ from switches");
	chk_inword_hold: assert property ($changed(o_in_word) |->
		s_recent_cmd)
		else $error("input word changed without a transfer");
endmodule // hbfs_core_asserts
bind hbfs_core hbfs_core_asserts #(.UV_CYC(UV_CYC), .SD_CYC(SD_CYC),
	.POR_CYC(POR_CYC)) hbfs_core_asserts_i (.i_clk(i_clk), .i_rstn(i_rstn),
	.i_sleep_control_pin(i_sleep_control_pin), .i_cs_n(i_cs_n),
	.i_sense(i_sense), .o_switch_on(o_switch_on),
	.o_current_limit(o_current_limit), .o_in_word(o_in_word),
	.o_out_word(o_out_word));
`default_nettype wire

// ### verification/hbfs_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
// Controller side of the serial link
module hbfs_mcu_model #(
	parameter int HALF = 25       // Clocks per half period, 2 MHz
) (
	input  wire logic i_clk,
	input  wire logic i_serial_out,
	output var  logic o_cs_n,
	output var  logic o_sclk,
	output var  logic o_serial_in_pin
);
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;            // Stands still outside frames
		o_serial_in_pin = 1'b0;
	end
	// LSB-first frame of n bits; fewer than 16 aborts it
	task automatic xfer(input logic [15:0] w, input int n,
		output logic [15:0] rd);
		rd = 16'h0000;
		@(negedge i_clk) o_cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			o_serial_in_pin = w[i];
			repeat (HALF) @(negedge i_clk);
			rd = {i_serial_out, rd[15:1]};   // Sampled before the rise
			o_sclk = 1'b1;
			repeat (HALF) @(negedge i_clk);
			o_sclk = 1'b0;
		end
		repeat (HALF) @(negedge i_clk);
		o_cs_n = 1'b1;                   // Early raise aborts
		o_serial_in_pin = ~o_serial_in_pin; // Inverted after the frame: no stale bit
	endtask
endmodule // hbfs_mcu_model
`default_nettype wire

// ### verification/hbfs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module hbfs_bench;
	logic                  i_clk = 1'b0;
	logic                  i_rstn = 1'b0;
	logic                  sleep = 1'b0;
	hbfs_pkg::hbfs_sense_t sense;
	wire logic             cs_n, sclk, din, so;
	logic [5:0]            sw_on;
	logic                  hiz, climit;
	logic [15:0]           in_word, out_word, rd;
	int                    n_mismatch = 0;
	int                    checks_done = 0;
	initial forever #5 i_clk = ~i_clk;
	hbfs_core #(.UV_CYC(4), .SD_CYC(4), .POR_CYC(8)) hbfs_core_i (
		.i_clk(i_clk), .i_rstn(i_rstn), .i_sleep_control_pin(sleep),
		.i_cs_n(cs_n), .i_sclk(sclk), .i_serial_in_pin(din),
		.i_sense(sense), .o_serial_out(so), .o_serial_out_en(),
		.o_switch_on(sw_on), .o_switch_hiz(hiz),
		.o_current_limit(climit), .o_in_word(in_word),
		.o_out_word(out_word));
	hbfs_mcu_model hbfs_mcu_model_i (.i_clk(i_clk), .i_serial_out(so),
		.o_cs_n(cs_n), .o_sclk(sclk), .o_serial_in_pin(din));
	// --------------------------------------------------------
	// Helpers
	// --------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		if (n_mismatch == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic hold(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	task automatic wr(input logic [15:0] w);
		hbfs_mcu_model_i.xfer(w, 16, rd);
		hold(4);
	endtask
	// Whole run is near 8k cycles; this cuts a hang
	initial begin
		#300000;
		n_mismatch++;
		close_out;
	end
	// --------------------------------------------------------
	// Tests
	// --------------------------------------------------------
	initial begin
		sense = '{uv: 1'b0, tp_set: 1'b0, tp_reset: 1'b1, tsd_off: 1'b0,
			tsd_on: 1'b1, open_ld: 6'h00, over_i: 6'h00};
		hold(8);
		i_rstn = 1'b1;
		hold(2);
		sleep = 1'b1;
		hold(20);
		check(in_word, 16'h2000);
		wr(16'h207E);
		check({10'h000, sw_on}, 16'h003F);
		sense.over_i = 6'h01;               // Shutdown enabled
		hold(12);
		check(out_word, 16'h207C);
		sense.over_i = 6'h00;
		wr(16'h207F);
		check(rd, 16'h207C);
		check(out_word, 16'h007E);
		wr(16'h007E);                       // Shutdown disabled
		sense.over_i = 6'h02;
		hold(12);
		check(out_word, 16'h207E);
		sense.over_i = 6'h00;
		wr(16'h007F);
		check(out_word, 16'h007E);
		sense.uv = 1'b1;
		hold(12);
		check(out_word, 16'h8000);
		sense.uv = 1'b0;
		hold(4);
		check(out_word, 16'h807E);
		wr(16'h007F);
		check(rd, 16'h807E);
		check(out_word, 16'h007E);
		sense.open_ld = 6'h04;              // Fault kept through reset
		hold(12);
		check(out_word, 16'h407E);
		wr(16'h007F);
		hold(12);
		check(out_word, 16'h407E);
		sense.open_ld = 6'h00;
		hold(4);
		check(out_word, 16'h407E);
		wr(16'h007F);
		check(out_word, 16'h007E);
		sense.tp_set = 1'b1;
		sense.tp_reset = 1'b0;
		hold(4);
		sense.tp_set = 1'b0;
		hold(4);
		check(out_word, 16'h007F);
		hbfs_mcu_model_i.xfer(16'h0000, 8, rd);
		check({15'h0000, rd[8]}, 16'h0001);
		hold(4);
		check(in_word, 16'h007E);
		check(out_word, 16'h007F);
		sense.tp_reset = 1'b1;
		hold(4);
		check(out_word, 16'h007E);
		sense.tsd_off = 1'b1;
		sense.tsd_on = 1'b0;
		hold(4);
		check(out_word, 16'h0000);
		sense.tsd_off = 1'b0;
		hold(8);
		check({10'h000, sw_on}, 16'h0000);
		sense.tsd_on = 1'b1;
		wr(16'h007F);
		check(out_word, 16'h007E);
		sleep = 1'b0;
		hold(4);
		check(out_word, 16'h0000);
		check({15'h0000, hiz}, 16'h0001);
		sleep = 1'b1;
		hold(20);
		wr(16'h2002);
		check({10'h000, sw_on}, 16'h0001);
		check({15'h0000, climit}, 16'h0001);
		close_out;
	end
endmodule // hbfs_bench
`default_nettype wire
